// >>> hdl/pfh_host.sv
// Operation
// - Reads drive chip select and output enable low, write strobe high.
// - Writes drive write strobe and chip select low, output enable high.
// - Shortened program mode takes two writes instead of four.
// - High voltage only for accelerated programming; pin never floats.
// - After standby, wait chip-select access time before sampling.
// - Host answers after a hardware reset so the user can restart an operation it cut off.
// - Host waits reset-high recovery before reading.
module pfh_host #(
    parameter int AW = 21,
    parameter int READY_CYCLES = pfh_pkg::READY_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // User request
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic REQ_CLEAR,
    input wire logic [AW:0] REQ_ADDR,
    input wire logic [15:0] REQ_WDATA,
    input wire logic REQ_BYTE_MODE,
    input wire logic [1:0] REQ_PA_MODE,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [15:0] RSP_RDATA,
    output logic RSP_TIMEOUT,
    // Flash pins
    output logic [AW-1:0] FL_ADDR,
    output logic [15:0] FL_DQ_O,
    output logic [15:0] FL_DQ_OE,
    input wire logic [15:0] FL_DQ_I,
    output logic FL_CE_N,
    output logic FL_OE_N,
    output logic FL_WE_N,
    output logic FL_RESET_N,
    output logic FL_BYTE_N,
    output logic FL_PA_HV,
    output logic FL_PA_LVL,
    input wire logic FL_OP_DONE_FLAG
);
    if (AW < 1 || AW > 24) begin : g_bad_aw
        $error("pfh_host: AW out of range");
    end
    if (READY_CYCLES < 1 || READY_CYCLES >= (1 << pfh_pkg::CNT_W)) begin : g_bad_ready
        $error("pfh_host: READY_CYCLES out of range");
    end

    localparam int CW = pfh_pkg::CNT_W;

    pfh_pkg::pfh_state_e st_reg, st_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [15:0] dqo_reg, dqo_next;
    logic [15:0] dqoe_reg, dqoe_next;
    logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
    logic rst_n_reg, rst_n_next, byte_n_reg, byte_n_next;
    logic pa_hv_reg, pa_hv_next, pa_lvl_reg, pa_lvl_next;
    logic ready_reg, ready_next, rv_reg, rv_next, to_reg, to_next;
    logic [15:0] rdata_reg, rdata_next;
    logic recov_reg, recov_next;
    logic load;
    logic [CW-1:0] load_val;
    logic expired;

    pfh_timer #(.W(CW)) u_timer (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .load(load),
        .value(load_val),
        .expired(expired)
    );

    always_comb begin
        st_next = st_reg;
        addr_next = addr_reg;
        dqo_next = dqo_reg;
        dqoe_next = dqoe_reg;
        ce_n_next = ce_n_reg;
        oe_n_next = oe_n_reg;
        we_n_next = we_n_reg;
        rst_n_next = rst_n_reg;
        byte_n_next = byte_n_reg;
        pa_hv_next = pa_hv_reg;
        pa_lvl_next = pa_lvl_reg;
        ready_next = 1'b0;
        rv_next = 1'b0;
        to_next = to_reg;
        rdata_next = rdata_reg;
        recov_next = recov_reg;
        load = 1'b0;
        load_val = '0;
        case (st_reg)
            pfh_pkg::ST_IDLE: begin
                // Deselected between accesses: standby, outputs released
                ce_n_next = 1'b1;
                oe_n_next = 1'b1;
                we_n_next = 1'b1;
                dqoe_next = '0;
                if (REQ_VALID && expired) begin
                    to_next = 1'b0;
                    byte_n_next = !REQ_BYTE_MODE;
                    // Level pin never floats; HV a distinct flag
                    pa_hv_next = (REQ_PA_MODE == pfh_pkg::PA_HV) && REQ_WRITE
                                 && !REQ_CLEAR;
                    pa_lvl_next = (REQ_PA_MODE != pfh_pkg::PA_LOW);
                    if (REQ_BYTE_MODE) begin
                        // Byte mode: lowest address on top data line
                        addr_next = REQ_ADDR[AW:1];
                    end else begin
                        addr_next = REQ_ADDR[AW-1:0];
                    end
                    if (REQ_CLEAR) begin
                        rst_n_next = 1'b0;
                        ce_n_next = 1'b1;
                        load = 1'b1;
                        load_val = CW'(pfh_pkg::RP_CYC);
                        st_next = pfh_pkg::ST_CLEAR;
                    end else if (REQ_WRITE) begin
                        // One bus write per request; user pairs two or four
                        ce_n_next = 1'b0;
                        we_n_next = 1'b0;
                        oe_n_next = 1'b1;
                        dqo_next = REQ_BYTE_MODE ? {REQ_ADDR[0], 7'h00, REQ_WDATA[7:0]}
                                                 : REQ_WDATA;
                        dqoe_next = REQ_BYTE_MODE ? 16'h80ff : 16'hffff;
                        load = 1'b1;
                        load_val = CW'(pfh_pkg::WP_CYC);
                        st_next = pfh_pkg::ST_WRITE;
                    end else begin
                        ce_n_next = 1'b0;
                        oe_n_next = 1'b0;
                        we_n_next = 1'b1;
                        dqo_next = {REQ_ADDR[0], 15'h0000};
                        dqoe_next = REQ_BYTE_MODE ? 16'h8000 : 16'h0000;
                        load = 1'b1;
                        // Leaving standby costs chip-select access time
                        load_val = CW'((pfh_pkg::CE_CYC > pfh_pkg::ACC_CYC) ?
                                       pfh_pkg::CE_CYC : pfh_pkg::ACC_CYC);
                        st_next = pfh_pkg::ST_READ;
                    end
                end
            end
            pfh_pkg::ST_READ: begin
                if (expired) begin
                    rdata_next = byte_lane_data(byte_n_reg, FL_DQ_I);
                    rv_next = 1'b1;
                    oe_n_next = 1'b1;
                    ce_n_next = 1'b1;
                    dqoe_next = '0;
                    st_next = pfh_pkg::ST_DONE;
                end
            end
            pfh_pkg::ST_WRITE: begin
                if (expired) begin
                    we_n_next = 1'b1; // Data latched on rising strobe
                    load = 1'b1;
                    load_val = CW'(pfh_pkg::WR_CYC);
                    st_next = pfh_pkg::ST_RECOVER;
                end
            end
            pfh_pkg::ST_RECOVER: begin
                if (expired) begin
                    // Program keeps running after deselect
                    ce_n_next = 1'b1;
                    dqoe_next = '0;
                    rv_next = 1'b1;
                    st_next = pfh_pkg::ST_DONE;
                end
            end
            pfh_pkg::ST_CLEAR: begin
                if (expired) begin
                    rst_n_next = 1'b1;
                    load = 1'b1;
                    load_val = CW'(READY_CYCLES);
                    st_next = pfh_pkg::ST_CLEAR_WAIT;
                end
            end
            pfh_pkg::ST_CLEAR_WAIT: begin
                // Busy low until internal reset ends, bounded wait
                if (FL_OP_DONE_FLAG || expired) begin
                    to_next = !FL_OP_DONE_FLAG;
                    recov_next = 1'b1;
                    load = 1'b1;
                    load_val = CW'(pfh_pkg::RH_CYC);
                    // Response lets the user restart a cut operation
                    rv_next = 1'b1;
                    st_next = pfh_pkg::ST_DONE;
                end
            end
            pfh_pkg::ST_DONE: begin
                // Next request only after timer clears (reset-high recovery)
                recov_next = 1'b0;
                ready_next = 1'b0;
                st_next = pfh_pkg::ST_IDLE;
            end
            default: st_next = pfh_pkg::ST_IDLE;
        endcase
        if (st_next == pfh_pkg::ST_IDLE && !(load) && expired && !req_taken(st_reg, REQ_VALID)) begin
            ready_next = 1'b1;
        end
    end

    function automatic logic [15:0] byte_lane_data(input logic bn, input logic [15:0] d);
        byte_lane_data = bn ? d : {8'h00, d[7:0]};
    endfunction

    function automatic logic req_taken(input pfh_pkg::pfh_state_e s, input logic v);
        req_taken = (s == pfh_pkg::ST_IDLE) && v;
    endfunction

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            st_reg <= pfh_pkg::ST_IDLE;
            addr_reg <= '0;
            dqo_reg <= '0;
            dqoe_reg <= '0;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            rst_n_reg <= 1'b1;
            byte_n_reg <= 1'b1;
            pa_hv_reg <= 1'b0;
            pa_lvl_reg <= 1'b1;
            ready_reg <= 1'b0;
            rv_reg <= 1'b0;
            to_reg <= 1'b0;
            rdata_reg <= '0;
            recov_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            addr_reg <= addr_next;
            dqo_reg <= dqo_next;
            dqoe_reg <= dqoe_next;
            ce_n_reg <= ce_n_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
            rst_n_reg <= rst_n_next;
            byte_n_reg <= byte_n_next;
            pa_hv_reg <= pa_hv_next;
            pa_lvl_reg <= pa_lvl_next;
            ready_reg <= ready_next;
            rv_reg <= rv_next;
            to_reg <= to_next;
            rdata_reg <= rdata_next;
            recov_reg <= recov_next;
        end
    end

    assign REQ_READY = ready_reg;
    assign RSP_VALID = rv_reg;
    assign RSP_RDATA = rdata_reg;
    assign RSP_TIMEOUT = to_reg;
    assign FL_ADDR = addr_reg;
    assign FL_DQ_O = dqo_reg;
    assign FL_DQ_OE = dqoe_reg;
    assign FL_CE_N = ce_n_reg;
    assign FL_OE_N = oe_n_reg;
    assign FL_WE_N = we_n_reg;
    assign FL_RESET_N = rst_n_reg;
    assign FL_BYTE_N = byte_n_reg;
    assign FL_PA_HV = pa_hv_reg;
    assign FL_PA_LVL = pa_lvl_reg;
endmodule // pfh_host

// >>> include/pfh_pkg.sv
package pfh_pkg;
    // Bus timing, all in ns; cycle counts derived at 250 MHz
    localparam int CLK_PERIOD_NS = 4;
    localparam int ADDRESS_ACCESS_TIME_NS = 90;
    localparam int CE_ACCESS_TIME_NS = 90;
    localparam int WRITE_PULSE_NS = 35;
    localparam int WRITE_RECOVER_NS = 30;
    localparam int MIN_CLEAR_PULSE_NS = 500;
    localparam int CLEAR_HIGH_RECOVERY_NS = 50;
    localparam int READY_TIMEOUT_NS = 20000;
    // Least times round up
    localparam int ACC_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CE_CYC = (CE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC = (WRITE_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC = (MIN_CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RH_CYC = (CLEAR_HIGH_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READY_CYC = READY_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    // Unlock-bypass program is two bus writes, normal program four
    localparam int BYPASS_WRITES = 2;
    localparam int NORMAL_WRITES = 4;
    // Protect/accelerate pin drive codes
    localparam logic [1:0] PA_LOW = 2'h0;
    localparam logic [1:0] PA_HIGH = 2'h1;
    localparam logic [1:0] PA_HV = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WRITE = 3'b010,
        ST_RECOVER = 3'b011,
        ST_CLEAR = 3'b100,
        ST_CLEAR_WAIT = 3'b101,
        ST_DONE = 3'b110
    } pfh_state_e;
endpackage

// >>> hdl/pfh_timer.sv
// Down counter for bus phase timing
module pfh_timer #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic expired
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = value;
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // Plain count test: gating with load would close a loop through the caller
    assign expired = (cnt_reg == '0);
endmodule // pfh_timer

// >>> verif/pfh_flash_model.sv
module pfh_flash_model (
    // Bus pins
    input wire logic [20:0] addr,
    input wire logic [15:0] dq_o,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic byte_n,
    input wire logic pa_hv,
    input wire logic pa_lvl,
    // Fault injection
    input wire logic stuck,
    output logic [15:0] dq_i,
    output logic op_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [15:0] rd;
    logic rd_en;
    int wcnt = 0;
    int busy_ns = 0;
    logic [15:0] cur;
    initial begin
        foreach (mem[i]) mem[i] = 16'h1000 + 16'(i);
        op_done = 1'b1;
    end
    assign rd_en = !ce_n && !oe_n && we_n && reset_n;
    // Entry picked by low address bits, a stand-in for sector select
    assign cur = mem[addr[3:0]];
    // Idle lanes show inverted data so a stale bus cannot pass; DQ15 is A-1 in byte mode
    assign rd = byte_n ? cur : {~cur[15:8], dq_o[15] ? cur[15:8] : cur[7:0]};
    assign dq_i = rd_en ? rd : ~last;
    always @(rd_en or rd) if (rd_en) last = rd;
    always @(posedge we_n) begin
        if (!ce_n && reset_n) begin
            wcnt = wcnt + 1;
            // Two writes with high voltage, four otherwise
            if (wcnt >= (pa_hv ? pfh_pkg::BYPASS_WRITES : pfh_pkg::NORMAL_WRITES)) begin
                wcnt = 0;
                if (pa_hv || pa_lvl || addr[3:0] != 4'hf) begin
                    if (byte_n) begin
                        mem[addr[3:0]] = dq_o;
                    end else if (dq_o[15]) begin
                        mem[addr[3:0]] = {dq_o[7:0], cur[7:0]};
                    end else begin
                        mem[addr[3:0]] = {cur[15:8], dq_o[7:0]};
                    end
                end
                op_done = 1'b0;
                busy_ns = 2000;
            end
        end
    end
    // Busy runs on while deselected and never blocks later writes
    always #1 begin
        if (busy_ns > 0) begin
            busy_ns = busy_ns - 1;
            if (busy_ns == 0) op_done = !stuck;
        end
    end
    always @(negedge reset_n) begin
        busy_ns = 0;
        wcnt = 0;
    end
    always @(posedge reset_n) if (!op_done) #100 op_done = !stuck;
endmodule // pfh_flash_model

// >>> verif/pfh_host_chk.sv
module pfh_host_chk (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Flash pins
    input wire logic [15:0] FL_DQ_OE,
    input wire logic FL_CE_N,
    input wire logic FL_OE_N,
    input wire logic FL_WE_N,
    input wire logic FL_RESET_N,
    input wire logic FL_BYTE_N,
    input wire logic FL_PA_HV
);
    int oe_low_reg, oe_low_next, rst_low_reg, rst_low_next;
    always_comb begin
        oe_low_next = FL_OE_N ? 0 : oe_low_reg + 1;
        rst_low_next = FL_RESET_N ? 0 : rst_low_reg + 1;
    end
    always_ff @(posedge CLK_SYS) begin
        oe_low_reg <= SYS_RST ? 0 : oe_low_next;
        rst_low_reg <= SYS_RST ? 0 : rst_low_next;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    a_read_levels: assert property (!FL_OE_N |-> !FL_CE_N && FL_WE_N
        && FL_DQ_OE == (FL_BYTE_N ? 16'h0000 : 16'h8000))
        else $error("read strobe levels wrong");
    a_hv_no_read: assert property (FL_PA_HV |-> FL_OE_N)
        else $error("high voltage during read");
    a_write_levels: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_RESET_N)
        else $error("write strobe levels wrong");
    a_write_pulse: assert property ($fell(FL_WE_N) |=> !FL_WE_N [*8])
        else $error("write pulse too short");
    a_write_lanes: assert property (!FL_WE_N |-> FL_DQ_OE == (FL_BYTE_N ? 16'hffff : 16'h80ff))
        else $error("write data lanes wrong");
    a_read_access: assert property ($rose(FL_OE_N) |-> oe_low_reg >= pfh_pkg::ACC_CYC)
        else $error("read sampled before access time");
    a_clear_pulse: assert property ($rose(FL_RESET_N) |-> rst_low_reg >= pfh_pkg::RP_CYC)
        else $error("clear pulse too short");
    a_clear_quiet: assert property (!FL_RESET_N |-> FL_CE_N && FL_OE_N && FL_WE_N && !FL_DQ_OE)
        else $error("bus active during clear");
    a_recover_wait: assert property ($rose(FL_RESET_N) |-> FL_CE_N [*8])
        else $error("access too soon after clear");
    a_byte_lanes: assert property (!FL_BYTE_N |-> FL_DQ_OE[14:8] == 7'h00)
        else $error("middle lanes driven in byte mode");
endmodule // pfh_host_chk

// >>> verif/pfh_host_bench.sv
module pfh_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic v = 1'b0, wr = 1'b0, clr = 1'b0, bm = 1'b0, stuck = 1'b0;
    logic [21:0] a = 22'h000000;
    logic [15:0] wd = 16'h0000;
    logic [1:0] pa = pfh_pkg::PA_HIGH;
    logic rdy, rv, to, ce_n, oe_n, we_n, rs_n, by_n, hv, lvl, done;
    logic [15:0] rdat, dqo, dqoe, dqi, dq;
    logic [20:0] fa;
    int num_errors = 0;
    int total_checks = 0;
    assign dq = (dqo & dqoe) | (dqi & ~dqoe);
    pfh_host #(.AW(21), .READY_CYCLES(50)) DUT (.CLK_SYS(clk), .SYS_RST(rst), .REQ_VALID(v),
        .REQ_WRITE(wr), .REQ_CLEAR(clr), .REQ_ADDR(a), .REQ_WDATA(wd), .REQ_BYTE_MODE(bm),
        .REQ_PA_MODE(pa), .REQ_READY(rdy), .RSP_VALID(rv), .RSP_RDATA(rdat), .RSP_TIMEOUT(to),
        .FL_ADDR(fa), .FL_DQ_O(dqo), .FL_DQ_OE(dqoe), .FL_DQ_I(dq), .FL_CE_N(ce_n),
        .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_RESET_N(rs_n), .FL_BYTE_N(by_n), .FL_PA_HV(hv),
        .FL_PA_LVL(lvl), .FL_OP_DONE_FLAG(done));
    pfh_flash_model u_flash (.addr(fa), .dq_o(dq), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .reset_n(rs_n), .byte_n(by_n), .pa_hv(hv), .pa_lvl(lvl), .stuck(stuck), .dq_i(dqi),
        .op_done(done));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic req(input logic w, input logic c, input logic [21:0] ad, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        v = 1'b1;
        wr = w;
        clr = c;
        a = ad;
        wd = d;
        while (ce_n === 1'b1 && rs_n === 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        v = 1'b0;
        while (rv !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("answer", 16'h0001, {15'h0000, rv});
    endtask
    task automatic rd_chk(input logic [21:0] ad, input logic [15:0] exp);
        req(1'b0, 1'b0, ad, 16'h0000);
        chk("read data", exp, rdat);
    endtask
    task automatic wr_n(input int n, input logic [21:0] ad, input logic [15:0] d);
        for (int i = 0; i < n; i++) req(1'b1, 1'b0, ad, d);
    endtask
    task automatic t_power_read;
        @(posedge clk);
        #1;
        chk("ready", 16'h0001, {15'h0000, rdy});
        rd_chk(22'h000003, 16'h1003);
        rd_chk(22'h000003, 16'h1003);
    endtask
    task automatic t_program;
        wr_n(2, 22'h000005, 16'hbeef);
        rd_chk(22'h000005, 16'h1005);
        wr_n(2, 22'h000005, 16'hbeef);
        rd_chk(22'h000005, 16'hbeef);
    endtask
    task automatic t_clear(input logic bad, input logic [15:0] exp_to);
        stuck = bad;
        req(1'b0, 1'b1, 22'h000000, 16'h0000);
        chk("timeout flag", exp_to, {15'h0000, to});
        stuck = 1'b0;
    endtask
    task automatic t_accel;
        pa = pfh_pkg::PA_HV;
        wr_n(2, 22'h000006, 16'h1234);
        rd_chk(22'h000006, 16'h1234);
        pa = pfh_pkg::PA_HIGH;
        wr_n(2, 22'h000007, 16'h4321);
        rd_chk(22'h000007, 16'h1007);
    endtask
    task automatic t_byte;
        bm = 1'b1;
        wr_n(4, 22'h000010, 16'h00a5);
        rd_chk(22'h000010, 16'h00a5);
        rd_chk(22'h000011, 16'h0010);
        bm = 1'b0;
    endtask
    task automatic t_protect;
        pa = pfh_pkg::PA_LOW;
        wr_n(4, 22'h00000f, 16'h7777);
        rd_chk(22'h00000f, 16'h100f);
        pa = pfh_pkg::PA_HIGH;
    endtask
    task automatic finish_test;
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_power_read();
        t_program();
        t_clear(1'b0, 16'h0000);
        rd_chk(22'h000005, 16'hbeef);
        t_accel();
        wait (done === 1'b1);
        t_clear(1'b0, 16'h0000);
        t_byte();
        t_protect();
        wr_n(4, 22'h000002, 16'h5555);
        t_clear(1'b1, 16'h0001);
        finish_test();
    end
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule // pfh_host_bench
bind pfh_host pfh_host_chk u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .FL_DQ_OE(FL_DQ_OE),
    .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N), .FL_RESET_N(FL_RESET_N),
    .FL_BYTE_N(FL_BYTE_N), .FL_PA_HV(FL_PA_HV));
